/* File: design/int_ctrl_pkg.sv */
// shared constants and types of the interrupt enable and dispatch block
package int_ctrl_pkg;

    // number of interrupt sources and priority levels
    localparam int unsigned NUM_SRC    = 18;
    localparam int unsigned NUM_LVL    = 4;
    localparam int unsigned LVL_W      = 2;
    localparam int unsigned NUM_W      = 5;

    // register offsets on the register port
    localparam logic [7:0] INT_ENABLE_C_OFF = 8'h9a;
    localparam logic [7:0] INT_ENABLE_A_OFF = 8'ha8;
    localparam logic [7:0] INT_ENABLE_B_OFF = 8'hb8;
    localparam logic [7:0] DISPATCH_STAT_OFF = 8'hfe;

    // reset values of the enable registers
    localparam logic [7:0] INT_ENABLE_A_RST = 8'h00;
    localparam logic [7:0] INT_ENABLE_B_RST = 8'h00;
    localparam logic [7:0] INT_ENABLE_C_RST = 8'h00;

    // field positions
    localparam int unsigned GLOBAL_INT_ENABLE_BIT = 7;
    localparam int unsigned ENB_RO_BIT            = 6;
    localparam int unsigned STAT_BUSY_BIT         = 7;

    // vector layout: first vector and spacing between two
    localparam logic [7:0] VECTOR_BASE = 8'h03;
    localparam logic [7:0] VECTOR_STEP = 8'h08;

    // sources whose cpu-level flag is cleared by hardware on vectoring:
    // radio done, converter, usart0 rx, usart1/audio rx, timers 1..4
    localparam logic [NUM_SRC-1:0] AUTO_CLR_MASK = 18'h01e0f;

    // sources whose peripheral has its own per-source mask bits
    localparam logic [NUM_SRC-1:0] MOD_MASK_SRC  = 18'h1bf41;

    // shared audio numbers (rx and tx)
    localparam int unsigned AUDIO_RX_NUM = 3;
    localparam int unsigned AUDIO_TX_NUM = 14;

    // timing in machine cycles: detection then the forced call
    localparam int unsigned DETECT_CYCLES = 1;
    localparam int unsigned CALL_CYCLES   = 6;
    localparam int unsigned CNT_W         = 3;

    // dispatch sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_DETECT = 3'b010,
        ST_CALL   = 3'b100
    } disp_state_e;

    // forced call carrier toward the cpu core
    typedef struct packed {
        logic [NUM_W-1:0] num;
        logic [7:0]       vector;
    } call_s;

endpackage

/* File: design/int_dispatch.sv */
// interrupt enable registers, pending flags and priority-gated dispatch
`timescale 1ns/1ps
module int_dispatch
    import int_ctrl_pkg::*;
#(
    parameter int unsigned MCYC_DIV = 1
) (
    input  wire logic                        ref_clk_i,
    input  wire logic                        rstn_i,
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic [7:0]                  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [7:0]                  reg_rdata_o,
    input  wire logic [NUM_SRC-1:0]          src_evt_i,
    input  wire logic [NUM_SRC-1:0]          mod_mask_any_i,
    input  wire logic [NUM_SRC-1:0]          mod_pending_i,
    input  wire logic [NUM_SRC-1:0]          mod_flag_clr_i,
    input  wire logic                        audio_rx_evt_i,
    input  wire logic                        audio_tx_evt_i,
    input  wire logic [NUM_SRC-1:0]          cpu_flag_clr_i,
    input  wire logic [NUM_SRC-1:0]          cpu_flag_set_i,
    input  wire logic [NUM_SRC*LVL_W-1:0]    prio_lvl_i,
    input  wire logic                        instr_boundary_i,
    input  wire logic                        reti_i,
    output logic [NUM_SRC-1:0]               cpu_flag_o,
    output logic                             call_start_o,
    output logic                             call_busy_o,
    output logic                             call_done_o,
    output call_s                            call_o,
    output logic [NUM_LVL-1:0]               active_lvl_o
);

    // vector address of an interrupt number
    function automatic logic [7:0] vector_of(input logic [NUM_W-1:0] num);
        logic [7:0] prod;
        prod = 8'({3'h0, num} * VECTOR_STEP);
        return 8'(VECTOR_BASE + prod);
    endfunction

    // map the three enable registers onto interrupt numbers
    function automatic logic [NUM_SRC-1:0] enables_of(input logic [7:0] ena,
                                                      input logic [7:0] enb,
                                                      input logic [7:0] enc);
        logic [NUM_SRC-1:0] e;
        e     = '0;
        e[0]  = ena[0];
        e[1]  = ena[1];
        e[2]  = ena[2];
        e[3]  = ena[3];
        e[4]  = ena[4];
        e[5]  = ena[5];
        e[6]  = enc[1];
        e[7]  = enc[2];
        e[8]  = enb[0];
        e[9]  = enb[1];
        e[10] = enb[2];
        e[11] = enb[3];
        e[12] = enb[4];
        e[13] = enb[5];
        e[14] = enc[3];
        e[15] = enc[4];
        e[16] = enc[0];
        e[17] = enc[5];
        return e;
    endfunction

    // highest set bit of the active level stack, valid flag in msb
    function automatic logic [LVL_W:0] top_level(input logic [NUM_LVL-1:0] act);
        logic [LVL_W:0] t;
        t = '0;
        for (int i = 0; i < NUM_LVL; i++) begin
            if (act[i]) begin
                t = {1'b1, LVL_W'(i)};
            end
        end
        return t;
    endfunction

    // priority level of one interrupt number
    function automatic logic [LVL_W-1:0] level_of(input logic [NUM_SRC*LVL_W-1:0] lvls,
                                                  input int                       num);
        return lvls[num*LVL_W +: LVL_W];
    endfunction

    // registers
    logic [7:0]          en_a_r, en_a_nxt;
    logic [7:0]          en_b_r, en_b_nxt;
    logic [7:0]          en_c_r, en_c_nxt;
    logic [7:0]          rdata_r, rdata_nxt;
    logic [NUM_SRC-1:0]  flag_r, flag_nxt;
    logic [NUM_LVL-1:0]  act_r, act_nxt;
    disp_state_e         state_r, state_nxt;
    logic [CNT_W-1:0]    cnt_r, cnt_nxt;
    call_s               call_r, call_nxt;
    logic [LVL_W-1:0]    lvl_r, lvl_nxt;
    logic                start_r, start_nxt;
    logic                done_r, done_nxt;
    logic [15:0]         div_r, div_nxt;
    logic                mcyc_en;

    // combinational helpers
    logic [NUM_SRC-1:0]  src_en;
    logic [NUM_SRC-1:0]  eligible;
    logic [LVL_W:0]      top;
    logic                win_vld;
    logic [NUM_W-1:0]    win_num;
    logic [LVL_W-1:0]    win_lvl;

    // machine cycle enable from the system clock divider
    // with the default divide of one the enable is high on every clock
    always_comb begin
        if (div_r >= 16'(MCYC_DIV - 1)) begin
            div_nxt = '0;
        end else begin
            div_nxt = 16'(div_r + 16'h0001);
        end
        mcyc_en = (div_r >= 16'(MCYC_DIV - 1));
    end

    // register writes and reads; read data stand one cycle later
    always_comb begin
        en_a_nxt  = en_a_r;
        en_b_nxt  = en_b_r;
        en_c_nxt  = en_c_r;
        rdata_nxt = 8'h00;
        if (reg_wr_i) begin
            case (reg_addr_i)
                INT_ENABLE_A_OFF: en_a_nxt = reg_wdata_i;
                INT_ENABLE_B_OFF: begin
                    en_b_nxt               = reg_wdata_i;
                    // bit 6 never stores a one, so it always reads back as zero
                    en_b_nxt[ENB_RO_BIT]   = 1'b0;
                end
                INT_ENABLE_C_OFF: en_c_nxt = reg_wdata_i;
                default:          ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                INT_ENABLE_A_OFF:  rdata_nxt = en_a_r;
                INT_ENABLE_B_OFF:  rdata_nxt = en_b_r;
                INT_ENABLE_C_OFF:  rdata_nxt = en_c_r;
                DISPATCH_STAT_OFF: begin
                    rdata_nxt                = {4'h0, act_r};
                    rdata_nxt[STAT_BUSY_BIT] = ~state_r[0];
                end
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // enabled sources, gated by the global enable
    always_comb begin
        src_en = enables_of(en_a_r, en_b_r, en_c_r);
        if (!en_a_r[GLOBAL_INT_ENABLE_BIT]) begin
            src_en = '0;
        end
    end

    // pick the winner: higher level than the running service, ties to low number
    always_comb begin
        top      = top_level(act_r);
        eligible = '0;
        win_vld  = 1'b0;
        win_num  = '0;
        win_lvl  = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            eligible[i] = flag_r[i] & src_en[i] &
                          (!top[LVL_W] || (level_of(prio_lvl_i, i) > top[LVL_W-1:0]));
        end
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!win_vld || level_of(prio_lvl_i, i) >= win_lvl)) begin
                win_vld = 1'b1;
                win_num = NUM_W'(i);
                win_lvl = level_of(prio_lvl_i, i);
            end
        end
    end

    // cpu-level flags: set wins over every clear
    // an event that lands in the vectoring cycle must not be lost to the auto-clear
    always_comb begin
        logic [NUM_SRC-1:0] set_v;
        logic [NUM_SRC-1:0] clr_v;
        set_v = '0;
        clr_v = cpu_flag_clr_i;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (MOD_MASK_SRC[i]) begin
                set_v[i] = src_evt_i[i] & mod_mask_any_i[i];
            end else begin
                set_v[i] = src_evt_i[i];
            end
            set_v[i] = set_v[i] | (mod_flag_clr_i[i] & mod_pending_i[i]);
        end
        set_v[AUDIO_RX_NUM] = set_v[AUDIO_RX_NUM] | audio_rx_evt_i;
        set_v[AUDIO_TX_NUM] = set_v[AUDIO_TX_NUM] | audio_tx_evt_i;
        set_v = set_v | cpu_flag_set_i;
        if (start_nxt && AUTO_CLR_MASK[call_nxt.num]) begin
            clr_v[call_nxt.num] = 1'b1;
        end
        flag_nxt = (flag_r & ~clr_v) | set_v;
    end

    // dispatch sequencer: detect one machine cycle, then six-cycle forced call
    // the winner is latched at the boundary so that a late flag cannot redirect a call
    // boundaries seen while busy are dropped; the flag stays pending for later
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        call_nxt  = call_r;
        lvl_nxt   = lvl_r;
        start_nxt = 1'b0;
        done_nxt  = 1'b0;
        act_nxt   = act_r;
        case (state_r)
            ST_IDLE: begin
                if (instr_boundary_i && win_vld) begin
                    state_nxt       = ST_DETECT;
                    call_nxt.num    = win_num;
                    call_nxt.vector = vector_of(win_num);
                    lvl_nxt         = win_lvl;
                    cnt_nxt         = CNT_W'(DETECT_CYCLES);
                end
            end
            ST_DETECT: begin
                if (mcyc_en) begin
                    cnt_nxt = CNT_W'(cnt_r - 3'h1);
                    if (cnt_r == CNT_W'(1)) begin
                        state_nxt      = ST_CALL;
                        start_nxt      = 1'b1;
                        act_nxt[lvl_r] = 1'b1;
                        cnt_nxt        = CNT_W'(CALL_CYCLES);
                    end
                end
            end
            ST_CALL: begin
                if (mcyc_en) begin
                    cnt_nxt = CNT_W'(cnt_r - 3'h1);
                    if (cnt_r == CNT_W'(1)) begin
                        state_nxt = ST_IDLE;
                        done_nxt  = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt   = '0;
            end
        endcase
        // a return always retires the highest level still in service
        if (reti_i && top[LVL_W]) begin
            act_nxt[top[LVL_W-1:0]] = 1'b0;
        end
    end

    // machine cycle divider register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // enable registers and read data register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_a_r  <= INT_ENABLE_A_RST;
            en_b_r  <= INT_ENABLE_B_RST;
            en_c_r  <= INT_ENABLE_C_RST;
            rdata_r <= 8'h00;
        end else begin
            en_a_r  <= en_a_nxt;
            en_b_r  <= en_b_nxt;
            en_c_r  <= en_c_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // cpu-level flag register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // dispatch sequencer registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_r   <= '0;
            state_r <= ST_IDLE;
            cnt_r   <= '0;
            call_r  <= '0;
            lvl_r   <= '0;
            start_r <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            act_r   <= act_nxt;
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            call_r  <= call_nxt;
            lvl_r   <= lvl_nxt;
            start_r <= start_nxt;
            done_r  <= done_nxt;
        end
    end

    // outputs, all from flip-flops
    // busy is decoded from the one-hot state register, so it cannot glitch
    assign reg_rdata_o  = rdata_r;
    assign cpu_flag_o   = flag_r;
    assign call_start_o = start_r;
    assign call_done_o  = done_r;
    assign call_busy_o  = ~state_r[0];
    assign call_o       = call_r;
    assign active_lvl_o = act_r;

endmodule

/* File: dv/int_dispatch_monitor.sv */
// port-level checks of the interrupt dispatch block
`timescale 1ns/1ps
module int_dispatch_monitor
    import int_ctrl_pkg::*;
(
    input wire logic               ref_clk_i,
    input wire logic               rstn_i,
    input wire logic [7:0]         reg_addr_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic [NUM_SRC-1:0] src_evt_i,
    input wire logic               instr_boundary_i,
    input wire logic [NUM_SRC-1:0] cpu_flag_o,
    input wire logic               call_start_o,
    input wire logic               call_busy_o,
    input wire logic               call_done_o,
    input wire call_s              call_o
);
    logic ea_r;
    logic ea_nxt;
    // shadow of the global enable bit
    always_comb begin
        ea_nxt = ea_r;
        if (reg_wr_i && reg_addr_i == INT_ENABLE_A_OFF) begin
            ea_nxt = reg_wdata_i[GLOBAL_INT_ENABLE_BIT];
        end
    end
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ea_r <= 1'b0;
        end else begin
            ea_r <= ea_nxt;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // detect cycle then the six-cycle call
    sequence detect_seq; $rose(call_busy_o) ##1 call_start_o; endsequence
    sequence run_seq; call_busy_o [*6] ##1 !call_busy_o; endsequence
    detect_call_a: assert property ($rose(call_busy_o) |-> detect_seq)
        else $error("call did not start one cycle after detect");
    call_length_a: assert property (call_start_o |-> run_seq)
        else $error("busy window not six cycles");
    done_six_a: assert property (call_start_o |-> ##6 call_done_o)
        else $error("call done not six cycles after start");
    vector_map_a: assert property (call_start_o |-> call_o.vector == 8'(8'h03 + 8'h08 * call_o.num))
        else $error("vector does not match number");
    global_gate_a: assert property ($rose(call_busy_o) |-> $past(ea_r))
        else $error("dispatch with global enable low");
    boundary_take_a: assert property ($rose(call_busy_o) |-> $past(instr_boundary_i))
        else $error("dispatch not at a boundary");
    auto_clear_a: assert property (call_start_o && AUTO_CLR_MASK[call_o.num] && $past(src_evt_i) == '0
        |-> !cpu_flag_o[call_o.num])
        else $error("auto flag not cleared on vectoring");
    flag_set_a: assert property ((src_evt_i & ~MOD_MASK_SRC) != '0
        |=> (cpu_flag_o & $past(src_evt_i & ~MOD_MASK_SRC)) == $past(src_evt_i & ~MOD_MASK_SRC))
        else $error("event did not set its flag");
endmodule

/* File: dv/cpu_core_model.sv */
// cpu core stand-in: instruction boundaries and return instructions
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic reti_req_i,
    output logic      instr_boundary_o,
    output logic      reti_o
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       pend_r;
    logic       pend_nxt;
    // boundary every third cycle, return issued at a boundary
    always_comb begin
        cnt_nxt = (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
        pend_nxt = (pend_r || reti_req_i) && !(cnt_r == 2'h2 && pend_r);
    end
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 2'h0;
            pend_r <= 1'b0;
            instr_boundary_o <= 1'b0;
            reti_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            instr_boundary_o <= (cnt_r == 2'h2);
            reti_o <= (cnt_r == 2'h2) && pend_r;
        end
    end
endmodule

/* File: dv/tb_cpu_interrupt_enable_and_dispatch.sv */
// self-checking bench of the interrupt dispatch block
`timescale 1ns/1ps
module tb_cpu_interrupt_enable_and_dispatch;
    import int_ctrl_pkg::*;
    logic ref_clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, audio_rx_evt_i = 0, reti_req = 0;
    logic audio_tx_evt_i = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, d;
    logic [NUM_SRC-1:0] src_evt_i = 0, mod_mask_any_i = 0, mod_pending_i = 0, mod_flag_clr_i = 0;
    logic [NUM_SRC-1:0] cpu_flag_clr_i = 0, cpu_flag_set_i = 0, cpu_flag_o;
    logic [NUM_SRC*LVL_W-1:0] prio_lvl_i = 0;
    logic instr_boundary_i, reti_i, call_start_o, call_busy_o, call_done_o;
    call_s call_o;
    logic [NUM_LVL-1:0] active_lvl_o;
    logic [7:0] map [18] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h21, 8'h22, 8'h10,
                             8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h23, 8'h24, 8'h20, 8'h25};
    logic [7:0] offs [3] = '{INT_ENABLE_A_OFF, INT_ENABLE_B_OFF, INT_ENABLE_C_OFF};
    int fails = 0, comparisons = 0, cycles = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    int_dispatch i_int_dispatch (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .src_evt_i(src_evt_i), .mod_mask_any_i(mod_mask_any_i), .mod_pending_i(mod_pending_i),
        .mod_flag_clr_i(mod_flag_clr_i), .audio_rx_evt_i(audio_rx_evt_i), .audio_tx_evt_i(audio_tx_evt_i),
        .cpu_flag_clr_i(cpu_flag_clr_i), .cpu_flag_set_i(cpu_flag_set_i), .prio_lvl_i(prio_lvl_i),
        .instr_boundary_i(instr_boundary_i), .reti_i(reti_i), .cpu_flag_o(cpu_flag_o),
        .call_start_o(call_start_o), .call_busy_o(call_busy_o), .call_done_o(call_done_o),
        .call_o(call_o), .active_lvl_o(active_lvl_o));
    cpu_core_model i_cpu_core_model (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reti_req_i(reti_req),
        .instr_boundary_o(instr_boundary_i), .reti_o(reti_i));
    // compare and count
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i); reg_addr_i <= a; reg_wdata_i <= v; reg_wr_i <= 1;
        @(posedge ref_clk_i); reg_wr_i <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i); reg_addr_i <= a; reg_rd_i <= 1;
        @(posedge ref_clk_i); reg_rd_i <= 0;
        #1 v = reg_rdata_o;
    endtask
    task automatic set_flag(input int n);
        @(posedge ref_clk_i); cpu_flag_set_i <= 18'h1 << n;
        @(posedge ref_clk_i); cpu_flag_set_i <= '0;
    endtask
    // watch one dispatch window, expect a call to number n or none
    task automatic take(input int n, input bit exp);
        bit got;
        got = 0;
        repeat (20) begin
            @(posedge ref_clk_i); #1;
            if (call_start_o === 1'b1 && !got) begin
                got = 1;
                check(call_o.num, 18'(n));
                check(call_o.vector, 18'(8'h03 + 8 * n));
            end
        end
        check(got, exp);
    endtask
    // software clears the cpu flag, then returns; ends at the edge that retires the level
    task automatic svc_end(input int n);
        @(posedge ref_clk_i); cpu_flag_clr_i <= 18'h1 << n; reti_req <= 1;
        @(posedge ref_clk_i); cpu_flag_clr_i <= '0; reti_req <= 0;
        @(posedge ref_clk_i iff reti_i);
    endtask
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rstn_i <= 1;
        for (int r = 0; r < 3; r++) begin
            rd(offs[r], d); check(d, 0);
        end
        wr(INT_ENABLE_B_OFF, 8'hff); rd(INT_ENABLE_B_OFF, d); check(d, 8'hbf);
        rd(8'h10, d); check(d, 0);
        // each source alone through its own enable bit
        for (int n = 0; n < 18; n++) begin
            for (int r = 0; r < 3; r++) begin
                wr(offs[r], (r == 0 ? 8'h80 : 8'h00) | (map[n][5:4] == r ? 8'h01 << map[n][2:0] : 8'h00));
            end
            set_flag(n); take(n, 1);
            check(cpu_flag_o[n], !AUTO_CLR_MASK[n]);
            svc_end(n);
        end
        wr(INT_ENABLE_A_OFF, 8'h01); set_flag(0); take(0, 0);
        check(cpu_flag_o[0], 1);
        wr(INT_ENABLE_A_OFF, 8'h80); take(0, 0);
        wr(INT_ENABLE_A_OFF, 8'h81); take(0, 1); svc_end(0);
        // priority, ties and preemption
        wr(INT_ENABLE_A_OFF, 8'hbf); wr(INT_ENABLE_B_OFF, 8'h3f); wr(INT_ENABLE_C_OFF, 8'h3f);
        prio_lvl_i <= 36'h1 << 10;
        @(posedge ref_clk_i); src_evt_i <= 18'h14;
        @(posedge ref_clk_i); src_evt_i <= '0;
        take(2, 1);
        take(4, 0);
        set_flag(5); take(5, 1);
        rd(DISPATCH_STAT_OFF, d); check(d, 8'h03);
        check(active_lvl_o, 4'h3);
        svc_end(5); svc_end(2);
        take(4, 1); svc_end(4);
        #1 check(active_lvl_o, 4'h0);
        // module flag clear with sources still pending
        @(posedge ref_clk_i); mod_pending_i <= 18'h80; mod_flag_clr_i <= 18'h80;
        @(posedge ref_clk_i); mod_flag_clr_i <= '0; mod_pending_i <= '0;
        take(7, 1); svc_end(7);
        // own mask bits gate the cpu flag
        @(posedge ref_clk_i); src_evt_i <= 18'h100;
        @(posedge ref_clk_i); src_evt_i <= '0;
        repeat (2) @(posedge ref_clk_i);
        check(cpu_flag_o[8], 0);
        mod_mask_any_i <= 18'h100;
        @(posedge ref_clk_i); src_evt_i <= 18'h100;
        @(posedge ref_clk_i); src_evt_i <= '0;
        take(8, 1); svc_end(8);
        @(posedge ref_clk_i); audio_rx_evt_i <= 1;
        @(posedge ref_clk_i); audio_rx_evt_i <= 0;
        take(3, 1); svc_end(3);
        @(posedge ref_clk_i); audio_tx_evt_i <= 1;
        @(posedge ref_clk_i); audio_tx_evt_i <= 0;
        take(14, 1); svc_end(14);
        finish_test();
    end
endmodule
bind int_dispatch int_dispatch_monitor i_int_dispatch_monitor (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .src_evt_i(src_evt_i),
    .instr_boundary_i(instr_boundary_i), .cpu_flag_o(cpu_flag_o), .call_start_o(call_start_o),
    .call_busy_o(call_busy_o), .call_done_o(call_done_o), .call_o(call_o));
